// *** design/cia_irq_accept.sv ***
// Purpose: Interrupt acceptance and nesting logic of a small CPU core
// Assumes: Core reports instruction ends on insn_done with insn_op
// Notes  : Core pushes the PC on pc_push and jumps on vec_load
`timescale 1ns/1ps
module cia_irq_accept #(
    parameter int          NSRC        = 8,
    parameter int          SAMPLE_DIV  = 4,
    parameter int          STACK_DEPTH = 8,
    parameter logic [15:0] NMI_VEC     = 16'h0004,
    parameter logic [15:0] VEC_BASE    = 16'h0006
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [7:0]       paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             filtered_ext_irq_pin,
    input  wire logic [NSRC-1:0]  src_req,
    input  wire logic             nmi_req,
    input  wire logic             insn_done,
    input  wire logic             insn_holds,
    input  wire cia_pkg::cia_op_t insn_op,
    output logic                  pc_push,
    output logic                  vec_load,
    output logic [15:0]           vec_addr,
    output logic                  busy,
    output logic [7:0]            status_out
);
    import cia_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int IW   = (NSRC > 1) ? $clog2(NSRC) : 1;
    localparam int DW   = (SAMPLE_DIV > 1) ? $clog2(SAMPLE_DIV) : 1;
    localparam int A_HI = LAT_HI_CYC;
    localparam int A_LO = LAT_LO_CYC;

    logic [NSRC-1:0] req_reg, mask_reg, level_reg;
    logic [7:0]      status_reg;
    logic [DW-1:0]   div_reg;
    logic            sample_en, pin_hit;
    logic            nmi_pend_reg, nmi_svc_reg, pop_pend_reg, first_reg;
    cia_state_t      state_reg;
    cia_kind_t       kind_reg;
    logic [6:0]      cnt_reg, tgt_reg;
    logic [NSRC-1:0] set_vec, elig, hi_elig;
    logic [IW-1:0]   win_idx;
    logic            win_lvl, ie, serviced_level_flag;
    logic            boundary, hold, op_brk, acc_nmi, acc_mask, acc_brk, acc_any;
    logic            wr_en, rd_setup, addr_ok, op_pop;

    cia_stack_if #(.W(8)) st_if ();

    // Lowest index is the fixed default order's winner
    function automatic logic [IW-1:0] first_set(input logic [NSRC-1:0] v);
        logic [IW-1:0] idx;
        idx = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = IW'(i);
            end
        end
        return idx;
    endfunction : first_set

    // ------------------------------------------------------------
    // Sampling clock for the pin filter
    // ------------------------------------------------------------
    // Divider giving one-cycle sample pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
        end else if (sample_en) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    assign sample_en = (div_reg == DW'(SAMPLE_DIV - 1));

    cia_noise_filter u_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin       (filtered_ext_irq_pin),
        .sample_en (sample_en),
        .hit       (pin_hit)
    );

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Zero wait states; unmapped addresses answer with an error
    assign addr_ok  = (paddr == OFS_REQ) || (paddr == OFS_MASK) || (paddr == OFS_LEVEL)
                   || (paddr == OFS_STATUS) || (paddr == OFS_STATE);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_ok;
    assign wr_en    = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;

    // Read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            case (paddr)
                OFS_REQ:    prdata <= 32'(req_reg);
                OFS_MASK:   prdata <= 32'(mask_reg);
                OFS_LEVEL:  prdata <= 32'(level_reg);
                OFS_STATUS: prdata <= 32'(status_reg);
                OFS_STATE:  prdata <= 32'({nmi_svc_reg, nmi_pend_reg, busy, kind_reg});
                default:    prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Acceptance decision
    // ------------------------------------------------------------
    assign ie  = status_reg[ACCEPT_EN_BIT];
    assign serviced_level_flag = status_reg[SERVICED_LVL_BIT];
    assign set_vec = src_req | NSRC'(pin_hit);

    // low level refused while high serviced
    assign elig    = req_reg & ~mask_reg & {NSRC{ie}} & ~(level_reg & {NSRC{~serviced_level_flag}});
    assign hi_elig = elig & ~level_reg;
    // higher level first, then default order
    assign win_idx = (|hi_elig) ? first_set(hi_elig) : first_set(elig);
    assign win_lvl = level_reg[win_idx];

    assign boundary = insn_done && (state_reg == ST_IDLE);
    assign op_brk   = (insn_op == OP_BREAK_TRAP);
    assign op_pop   = (insn_op == OP_INTERRUPT_RETURN) || (insn_op == OP_BREAK_RETURN)
                   || (insn_op == OP_POP_STATUS);
    // status-touching ops defer acceptance by one instruction
    assign hold = insn_holds || op_pop || (insn_op == OP_PUSH_STATUS)
               || (insn_op == OP_GLOBAL_ENABLE) || (insn_op == OP_GLOBAL_MASK);

    assign acc_brk  = boundary && op_brk;
    assign acc_nmi  = boundary && !op_brk && !hold && nmi_pend_reg && !nmi_svc_reg;
    assign acc_mask = boundary && !op_brk && !hold && !(nmi_pend_reg && !nmi_svc_reg)
                   && !nmi_svc_reg && (|elig);
    assign acc_any  = acc_brk || acc_nmi || acc_mask;

    // ------------------------------------------------------------
    // Request, mask and level flags
    // ------------------------------------------------------------
    // cleared on accept or write; a new request wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= '0;
        end else begin
            req_reg <= ((wr_en && paddr == OFS_REQ) ? pwdata[NSRC-1:0] : req_reg)
                     & ~(acc_mask ? (NSRC'(1) << win_idx) : '0) | set_vec;
        end
    end

    // Mask and level flags are plain software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg  <= NSRC'(MASK_RST);
            level_reg <= NSRC'(LEVEL_RST);
        end else if (wr_en && paddr == OFS_MASK) begin
            mask_reg <= pwdata[NSRC-1:0];
        end else if (wr_en && paddr == OFS_LEVEL) begin
            level_reg <= pwdata[NSRC-1:0];
        end
    end

    // ------------------------------------------------------------
    // Status word and its stack
    // ------------------------------------------------------------
    // reset value
    // restore after pop; acceptance beats a bus write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= STATUS_RST;
        end else if (pop_pend_reg) begin
            status_reg <= st_if.rdata;
        end else if (acc_any) begin
            status_reg[ACCEPT_EN_BIT] <= 1'b0;
            if (acc_mask) begin
                status_reg[SERVICED_LVL_BIT] <= win_lvl;
            end else if (acc_nmi) begin
                status_reg[SERVICED_LVL_BIT] <= 1'b0;
            end
        end else if (boundary && insn_op == OP_GLOBAL_ENABLE) begin
            status_reg[ACCEPT_EN_BIT] <= 1'b1;
        end else if (boundary && insn_op == OP_GLOBAL_MASK) begin
            status_reg[ACCEPT_EN_BIT] <= 1'b0;
        end else if (wr_en && paddr == OFS_STATUS) begin
            status_reg <= pwdata[7:0];
        end
    end

    assign st_if.push  = acc_any || (boundary && insn_op == OP_PUSH_STATUS);
    assign st_if.pop   = boundary && op_pop;
    assign st_if.wdata = status_reg;

    // Popped word arrives one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_pend_reg <= 1'b0;
        end else begin
            pop_pend_reg <= st_if.pop;
        end
    end

    cia_stack_mem #(.DEPTH(STACK_DEPTH)) u_stack (
        .pclk    (pclk),
        .presetn (presetn),
        .st      (st_if.mem)
    );

    // ------------------------------------------------------------
    // Non-maskable tracking
    // ------------------------------------------------------------
    // one held request, new arrival beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_pend_reg <= 1'b0;
            nmi_svc_reg  <= 1'b0;
        end else begin
            nmi_pend_reg <= nmi_req || (nmi_pend_reg && !acc_nmi);
            if (acc_nmi) begin
                nmi_svc_reg <= 1'b1;
            end else if (boundary && insn_op == OP_INTERRUPT_RETURN) begin
                nmi_svc_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Stacking sequence and vectoring
    // ------------------------------------------------------------
    // latency from acceptance to vector load fixed per level: LAT_HI_CYC (13) for high, LAT_LO_CYC (15) for low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            kind_reg  <= KIND_NONE;
            cnt_reg   <= '0;
            tgt_reg   <= '0;
            vec_addr  <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= '0;
                    if (acc_any) begin
                        state_reg <= ST_STACK;
                        tgt_reg   <= (acc_mask && win_lvl) ? 7'(LAT_LO_CYC - 1) : 7'(LAT_HI_CYC - 1);
                        if (acc_brk) begin
                            kind_reg <= KIND_BRK;
                            vec_addr <= BRK_VEC;
                        end else if (acc_nmi) begin
                            kind_reg <= KIND_NMI;
                            vec_addr <= NMI_VEC;
                        end else begin
                            kind_reg <= KIND_MASK;
                            vec_addr <= VEC_BASE + 16'({win_idx, 1'b0});
                        end
                    end
                end
                ST_STACK: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == tgt_reg) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Status word is stacked first, then the core pushes the PC
    assign busy       = (state_reg == ST_STACK);
    assign pc_push    = busy && (cnt_reg == tgt_reg - 7'h01);
    assign vec_load   = busy && (cnt_reg == tgt_reg);
    assign status_out = status_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // First cycle after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    a_status_reset: assert property (@(posedge pclk) disable iff (!presetn)
        first_reg |-> status_reg == STATUS_RST) else $error("status word not 02H after reset");

    a_accept_ie_clear: assert property (@(posedge pclk) disable iff (!presetn)
        acc_any |=> !status_reg[ACCEPT_EN_BIT] && busy) else $error("enable not cleared");

    a_serviced_copy: assert property (@(posedge pclk) disable iff (!presetn)
        acc_mask |=> status_reg[SERVICED_LVL_BIT] == $past(win_lvl)) else $error("level not copied");

    a_nmi_wins: assert property (@(posedge pclk) disable iff (!presetn)
        boundary && !hold && !op_brk && nmi_pend_reg && !nmi_svc_reg |-> acc_nmi && !acc_mask)
        else $error("NMI lost precedence");

    // NMI clears both flags and vectors
    a_nmi_flags: assert property (@(posedge pclk) disable iff (!presetn)
        acc_nmi |=> !status_reg[ACCEPT_EN_BIT] && !status_reg[SERVICED_LVL_BIT] && vec_addr == NMI_VEC)
        else $error("NMI flags or vector wrong");

    a_nmi_no_nest: assert property (@(posedge pclk) disable iff (!presetn)
        nmi_svc_reg |-> !acc_nmi && !acc_mask) else $error("nesting during NMI");

    a_mask_elig: assert property (@(posedge pclk) disable iff (!presetn)
        acc_mask |-> req_reg[win_idx] && !mask_reg[win_idx] && ie && (serviced_level_flag || !win_lvl))
        else $error("ineligible request accepted");

    a_lat_high: assert property (@(posedge pclk) disable iff (!presetn)
        (acc_mask || acc_nmi) && !(acc_mask && win_lvl) |=> !vec_load [*8] ##1 !vec_load [*4] ##1 vec_load)
        else $error("high level latency wrong");
    a_lat_high_end: assert property (@(posedge pclk) disable iff (!presetn)
        acc_mask && !win_lvl |-> ##A_HI vec_load) else $error("high level vector late");

    a_lat_low: assert property (@(posedge pclk) disable iff (!presetn)
        acc_mask && win_lvl |-> ##A_LO vec_load ##1 !busy) else $error("low level latency wrong");

    a_brk_vector: assert property (@(posedge pclk) disable iff (!presetn)
        acc_brk |-> ##A_HI vec_load && vec_addr == BRK_VEC) else $error("break vector wrong");

    a_req_clear: assert property (@(posedge pclk) disable iff (!presetn)
        acc_mask && !set_vec[win_idx] |=> !req_reg[$past(win_idx)]) else $error("flag not cleared");
endmodule : cia_irq_accept

// *** design/cia_noise_filter.sv ***
// Purpose: Pin synchroniser and two-sample noise check
// Assumes: sample_en is a one-cycle pulse from the sampling divider
// Notes  : Active level is high; one hit per active stretch
`timescale 1ns/1ps
module cia_noise_filter (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    input  wire logic sample_en,
    output logic      hit
);
    logic s1_reg, s2_reg, s3_reg, lvl_reg, prev_reg, armed_reg;

    // Three-stage synchroniser; level moves once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            lvl_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                lvl_reg <= s3_reg;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg  <= 1'b0;
            armed_reg <= 1'b1;
            hit       <= 1'b0;
        end else begin
            hit <= sample_en && lvl_reg && prev_reg && armed_reg;
            if (sample_en) begin
                prev_reg  <= lvl_reg;
                armed_reg <= !(lvl_reg && prev_reg) && (armed_reg || !lvl_reg);
            end
        end
    end
endmodule : cia_noise_filter

// *** design/cia_stack_mem.sv ***
// Purpose: Small stack of saved status words
// Assumes: Pops from an empty stack are ignored
// Notes  : Pushes beyond the depth are dropped
`timescale 1ns/1ps
module cia_stack_mem #(
    parameter int DEPTH = 8
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    cia_stack_if.mem   st
);
    localparam int AW = $clog2(DEPTH);
    logic [7:0]  mem [DEPTH];
    logic [AW:0] sp_reg;

    // Pointer and registered read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg   <= '0;
            st.rdata <= '0;
        end else if (st.push && (sp_reg < (AW+1)'(DEPTH))) begin
            sp_reg <= sp_reg + 1'b1;
        end else if (st.pop && (sp_reg != '0)) begin
            sp_reg   <= sp_reg - 1'b1;
            st.rdata <= mem[AW'(sp_reg - 1'b1)];
        end
    end

    // Storage needs no reset
    always_ff @(posedge pclk) begin
        if (st.push && (sp_reg < (AW+1)'(DEPTH))) begin
            mem[AW'(sp_reg)] <= st.wdata;
        end
    end
endmodule : cia_stack_mem

// *** inc/cia_pkg.sv ***
// Purpose: Shared constants and types of the interrupt acceptance block
// Assumes: CPU clock equals pclk (25 MHz, 40 ns)
// Notes  : Register offsets are byte addresses on the APB
package cia_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_REQ    = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h04;
    localparam logic [7:0] OFS_LEVEL  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_STATE  = 8'h10;
    localparam logic [7:0] MASK_RST   = 8'hFF;
    localparam logic [7:0] LEVEL_RST  = 8'hFF;
    localparam logic [7:0] STATUS_RST = 8'h02;
    localparam int ACCEPT_EN_BIT      = 7;
    localparam int SERVICED_LVL_BIT   = 1;
    localparam logic [15:0] BRK_VEC   = 16'h003E;
    // ------------------------------------------------------------
    // Timing: latency in CPU clocks, converted to pclk cycles
    // ------------------------------------------------------------
    localparam int CPU_DIV     = 1;
    localparam int LAT_HI_CLK  = 13;
    localparam int LAT_LO_CLK  = 15;
    localparam int LAT_HI_CYC  = LAT_HI_CLK * CPU_DIV;
    localparam int LAT_LO_CYC  = LAT_LO_CLK * CPU_DIV;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_BREAK_TRAP, OP_INTERRUPT_RETURN, OP_BREAK_RETURN,
        OP_PUSH_STATUS, OP_POP_STATUS, OP_GLOBAL_ENABLE, OP_GLOBAL_MASK
    } cia_op_t;
    typedef enum logic [1:0] {KIND_NONE, KIND_NMI, KIND_MASK, KIND_BRK} cia_kind_t;
    typedef enum logic {ST_IDLE, ST_STACK} cia_state_t;
endpackage : cia_pkg

// *** inc/cia_stack_if.sv ***
// Purpose: Status word stack port between controller and stack memory
// Assumes: push and pop are one-cycle pulses, never together
// Notes  : rdata is valid the cycle after a pop
`timescale 1ns/1ps
interface cia_stack_if #(parameter int W = 8);
    logic         push;
    logic         pop;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    modport ctrl (output push, output pop, output wdata, input rdata);
    modport mem  (input push, input pop, input wdata, output rdata);
endinterface : cia_stack_if

// *** sim/cia_core_model.sv ***
// Purpose: Core side model: instruction ends and vector fetch
// Assumes: Acceptance is taken at the instruction end edge
// Notes  : A call gives up after 30 cycles with no vector load
`timescale 1ns/1ps
module cia_core_model (
    input  wire logic        pclk,
    input  wire logic        vec_load,
    input  wire logic        pc_push,
    output cia_pkg::cia_op_t insn_op = cia_pkg::OP_NONE,
    output logic             insn_done = 1'b0,
    output logic             insn_holds = 1'b0
);
    import cia_pkg::*;
    task automatic run(input cia_op_t op, input logic hd, output int lat, output int pl);
        @(posedge pclk);
        insn_done  <= 1'b1;
        insn_op    <= op;
        insn_holds <= hd;
        @(posedge pclk);
        insn_done  <= 1'b0;
        insn_holds <= 1'b0;
        lat = 0;
        pl  = 0;
        // Falling edge sampling avoids racing the design's update
        do begin
            @(negedge pclk);
            lat++;
            if (pc_push === 1'b1) pl = lat;
        end while (lat < 30 && vec_load !== 1'b1);
    endtask : run
endmodule : cia_core_model

// *** sim/test_cpu_interrupt_acceptance.sv ***
// Purpose: Self-checking bench of the acceptance block
// Assumes: Sample divider cut to 2; vector bases are test values
// Notes  : Latency counts cycles from instruction end to vector load
`timescale 1ns/1ps
module test_cpu_interrupt_acceptance;
    import cia_pkg::*;
    localparam logic [15:0] NV = 16'h0004;
    localparam logic [15:0] VB = 16'h0006;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pin = 1'b0, nmi_req = 1'b0, pready, insn_done, insn_holds, vec_load;
    logic [7:0]  paddr = 8'h00, src_req = 8'h00, status_out;
    logic [15:0] vec_addr;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        se, pslverr, busy, pc_push;
    cia_op_t     insn_op;
    int          err_count = 0, checks_done = 0;
    cia_irq_accept #(.SAMPLE_DIV(2), .NMI_VEC(NV), .VEC_BASE(VB)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .filtered_ext_irq_pin(pin),
        .src_req(src_req), .nmi_req(nmi_req), .insn_done(insn_done), .insn_holds(insn_holds),
        .insn_op(insn_op), .pc_push(pc_push), .vec_load(vec_load), .vec_addr(vec_addr), .busy(busy),
        .status_out(status_out));
    cia_core_model core (.pclk(pclk), .vec_load(vec_load), .pc_push(pc_push), .insn_op(insn_op),
        .insn_done(insn_done), .insn_holds(insn_holds));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // APB transfer; a read is compared with d
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!w) chk(rd, d);
    endtask : acc
    task automatic st(input logic [7:0] e);
        chk({24'h0, status_out}, {24'h0, e});
    endtask : st
    // A latency of 30 means nothing was accepted
    // PC push comes one cycle before the vector load; busy stands through it
    task automatic step(input cia_op_t op, input logic [15:0] ev, input int el, input logic hd = 1'b0);
        int l, p;
        core.run(op, hd, l, p);
        chk(l, el);
        chk(p, (el < 30) ? el - 1 : 0);
        chk({31'h0, busy}, {31'h0, el < 30});
        if (el < 30) chk({16'h0, vec_addr}, {16'h0, ev});
    endtask : step
    task automatic pulse(input logic [7:0] s, input logic n);
        @(posedge pclk);
        src_req <= s;
        nmi_req <= n;
        @(posedge pclk);
        src_req <= 8'h00;
        nmi_req <= 1'b0;
    endtask : pulse
    task automatic end_of_test;
        $display("err_count=%0d checks_done=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        forever #20 pclk = ~pclk;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (4000) @(posedge pclk);
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, OFS_STATUS, 32'h02);
        acc(1'b0, OFS_MASK, 32'hFF);
        chk({31'h0, se}, 32'h0);
        acc(1'b0, 8'h20, 32'h0);
        chk({31'h0, se}, 32'h1);
        @(posedge pclk);
        pin <= 1'b1;
        repeat (20) @(posedge pclk);
        pin <= 1'b0;
        acc(1'b0, OFS_REQ, 32'h01);
        acc(1'b1, OFS_REQ, 32'h0);
        acc(1'b1, OFS_MASK, 32'hF9);
        acc(1'b1, OFS_LEVEL, 32'hFB);
        acc(1'b1, OFS_STATUS, 32'h82);
        pulse(8'h06, 1'b0);
        step(OP_NONE, VB + 16'h4, 13);
        st(8'h00);
        acc(1'b1, OFS_STATUS, 32'h80);
        step(OP_NONE, 16'h0, 30);
        acc(1'b1, OFS_STATUS, 32'h82);
        step(OP_NONE, VB + 16'h2, 15);
        st(8'h02);
        acc(1'b1, OFS_STATUS, 32'h82);
        step(OP_BREAK_TRAP, BRK_VEC, 13);
        st(8'h02);
        step(OP_BREAK_RETURN, 16'h0, 30);
        st(8'h82);
        pulse(8'h04, 1'b1);
        step(OP_NONE, NV, 13);
        st(8'h00);
        pulse(8'h00, 1'b1);
        pulse(8'h00, 1'b1);
        step(OP_GLOBAL_ENABLE, 16'h0, 30);
        step(OP_NONE, 16'h0, 30);
        step(OP_INTERRUPT_RETURN, 16'h0, 30);
        step(OP_NONE, NV, 13);
        step(OP_INTERRUPT_RETURN, 16'h0, 30);
        step(OP_NONE, VB + 16'h4, 13);
        acc(1'b1, OFS_STATUS, 32'h82);
        pulse(8'h02, 1'b0);
        step(OP_NONE, 16'h0, 30, 1'b1);
        step(OP_NONE, VB + 16'h2, 15);
        end_of_test();
    end
endmodule : test_cpu_interrupt_acceptance
